// ---- rps_pkg.sv ----
package rps_pkg;
    // register byte addresses
    localparam logic [7:0] RPS_ADDR_TMR_SEL = 8'h00;
    localparam logic [7:0] RPS_ADDR_OUT_SEL1 = 8'h04;
    localparam logic [7:0] RPS_ADDR_OUT_SEL2 = 8'h08;
    localparam int RPS_ADDR_W = 8;
    // input-select field layout
    localparam int RPS_T9_LSB = 8;
    localparam int RPS_T8_LSB = 0;
    localparam int RPS_IN_W = 7;
    // output-select field layout
    localparam int RPS_HI_LSB = 8;
    localparam int RPS_LO_LSB = 0;
    localparam int RPS_FN_W = 6;
    localparam logic [15:0] RPS_TMR_MASK = 16'h7f7f;
    localparam logic [15:0] RPS_OUT_MASK = 16'h3f3f;
    localparam logic [15:0] RPS_RESET_VAL = 16'h0000;
    // fixed input codes
    localparam logic [6:0] RPS_CODE_GND = 7'h00;
    localparam logic [6:0] RPS_CODE_COMPARATOR1_OUTPUT = 7'h01;
    localparam logic [6:0] RPS_CODE_FIRST_PIN = 7'h2b;
    localparam int RPS_NUM_IN = 128;
    localparam int RPS_NUM_FN = 64;
    localparam logic [1:0] RPS_HTRANS_NONSEQ = 2'b10;
endpackage : rps_pkg

// ---- remappable_pin_select.sv ----
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module remappable_pin_select
    import rps_pkg::*;
#(
    // bit n set where input code n reaches a pin
    parameter logic [127:0] PIN_PRESENT = 128'hf3c3_317f_0300_0000_0000_1800_0000_0000
) (
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    input  wire logic                  clkEn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic [RPS_NUM_IN-1:0] remappablePinIn,
    input  wire logic                  comparator1Output,
    input  wire logic [RPS_NUM_FN-1:0] peripheralFunctionOut,
    output logic                       timer8ExternalClock,
    output logic                       timer9ExternalClock,
    output logic                       remapPin66,
    output logic                       remapPin67,
    output logic                       remapPin68,
    output logic                       remapPin69
);
    ////////////////////////////////////////////////////////////////////////////////
    // pick one input source per code
    function automatic logic selectInput(input logic [6:0] code, input logic [RPS_NUM_IN-1:0] pins,
                                         input logic cmp);
        logic res;
        res = 1'b0;
        if (code == RPS_CODE_GND)
            res = 1'b0;
        else if (code == RPS_CODE_COMPARATOR1_OUTPUT)
            res = cmp;
        else if (code >= RPS_CODE_FIRST_PIN && PIN_PRESENT[code])
            res = pins[code];
        return res;
    endfunction : selectInput

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [RPS_NUM_IN-1:0] pinMeta_ff, pinSync_ff, nxt_pinMeta, nxt_pinSync;
    logic                  cmpMeta_ff, cmpSync_ff, nxt_cmpMeta, nxt_cmpSync;

    always_comb begin
        nxt_pinMeta = remappablePinIn;
        nxt_pinSync = pinMeta_ff;
        nxt_cmpMeta = comparator1Output;
        nxt_cmpSync = cmpMeta_ff;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pinMeta_ff <= '0;
            pinSync_ff <= '0;
            cmpMeta_ff <= 1'b0;
            cmpSync_ff <= 1'b0;
        end else if (clkEn) begin
            pinMeta_ff <= nxt_pinMeta;
            pinSync_ff <= nxt_pinSync;
            cmpMeta_ff <= nxt_cmpMeta;
            cmpSync_ff <= nxt_cmpSync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // ahb-lite slave and registers
    logic [15:0]           tmrSel_ff, outSel1_ff, outSel2_ff;
    logic [15:0]           nxt_tmrSel, nxt_outSel1, nxt_outSel2;
    logic                  wrPend_ff, nxt_wrPend;
    logic [RPS_ADDR_W-1:0] wrAddr_ff, nxt_wrAddr;
    logic [31:0]           rdData_ff, nxt_rdData;
    logic                  addrPhase;

    assign addrPhase = hsel && hready && htrans == RPS_HTRANS_NONSEQ;

    always_comb begin
        nxt_tmrSel  = tmrSel_ff;
        nxt_outSel1 = outSel1_ff;
        nxt_outSel2 = outSel2_ff;
        nxt_wrPend  = addrPhase && hwrite;
        nxt_wrAddr  = haddr[RPS_ADDR_W-1:0];
        nxt_rdData  = 32'h0000_0000;
        if (wrPend_ff) begin
            if (wrAddr_ff == RPS_ADDR_TMR_SEL)
                nxt_tmrSel = hwdata[15:0] & RPS_TMR_MASK;
            if (wrAddr_ff == RPS_ADDR_OUT_SEL1)
                nxt_outSel1 = hwdata[15:0] & RPS_OUT_MASK;
            if (wrAddr_ff == RPS_ADDR_OUT_SEL2)
                nxt_outSel2 = hwdata[15:0] & RPS_OUT_MASK;
        end
        if (addrPhase && !hwrite) begin
            case (haddr[RPS_ADDR_W-1:0])
                RPS_ADDR_TMR_SEL: begin
                    nxt_rdData = {16'h0000, nxt_tmrSel};
                end
                RPS_ADDR_OUT_SEL1: begin
                    nxt_rdData = {16'h0000, nxt_outSel1};
                end
                RPS_ADDR_OUT_SEL2: begin
                    nxt_rdData = {16'h0000, nxt_outSel2};
                end
                default: begin
                    nxt_rdData = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tmrSel_ff  <= RPS_RESET_VAL;
            outSel1_ff <= RPS_RESET_VAL;
            outSel2_ff <= RPS_RESET_VAL;
            wrPend_ff  <= 1'b0;
            wrAddr_ff  <= '0;
            rdData_ff  <= 32'h0000_0000;
        end else if (clkEn) begin
            tmrSel_ff  <= nxt_tmrSel;
            outSel1_ff <= nxt_outSel1;
            outSel2_ff <= nxt_outSel2;
            wrPend_ff  <= nxt_wrPend;
            wrAddr_ff  <= nxt_wrAddr;
            rdData_ff  <= nxt_rdData;
        end
    end

    assign hrdata    = rdData_ff;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // routing to timers and pins
    logic [5:0] fn66, fn67, fn68, fn69;
    logic [5:0] outPins_ff, nxt_outPins;

    assign fn67 = outSel1_ff[RPS_HI_LSB +: RPS_FN_W];
    assign fn66 = outSel1_ff[RPS_LO_LSB +: RPS_FN_W];
    assign fn69 = outSel2_ff[RPS_HI_LSB +: RPS_FN_W];
    assign fn68 = outSel2_ff[RPS_LO_LSB +: RPS_FN_W];

    always_comb begin
        // decode timer 8 and 9 sources, then route functions to pins 66 to 69
        nxt_outPins[0] = selectInput(tmrSel_ff[RPS_T8_LSB +: RPS_IN_W], pinSync_ff, cmpSync_ff);
        nxt_outPins[1] = selectInput(tmrSel_ff[RPS_T9_LSB +: RPS_IN_W], pinSync_ff, cmpSync_ff);
        nxt_outPins[2] = peripheralFunctionOut[fn66];
        nxt_outPins[3] = peripheralFunctionOut[fn67];
        nxt_outPins[4] = peripheralFunctionOut[fn68];
        nxt_outPins[5] = peripheralFunctionOut[fn69];
    end

    always_ff @(posedge ref_clk) begin
        if (reset)
            outPins_ff <= 6'h00;
        else if (clkEn)
            outPins_ff <= nxt_outPins;
    end

    assign timer8ExternalClock = outPins_ff[0];
    assign timer9ExternalClock = outPins_ff[1];
    assign remapPin66          = outPins_ff[2];
    assign remapPin67          = outPins_ff[3];
    assign remapPin68          = outPins_ff[4];
    assign remapPin69          = outPins_ff[5];

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_out_sel_unimpl: assert property (@(posedge ref_clk) disable iff (reset)
        (outSel1_ff & ~RPS_OUT_MASK) == 16'h0000 && (outSel2_ff & ~RPS_OUT_MASK) == 16'h0000)
        else $error("unimplemented output-select bits set");
    a_tmr_sel_reset: assert property (@(posedge ref_clk) $past(reset) |-> tmrSel_ff == 16'h0000)
        else $error("input select not zero after reset");
    a_gnd_select: assert property (@(posedge ref_clk) disable iff (reset)
        clkEn && tmrSel_ff[6:0] == 7'h00 |=> !timer8ExternalClock)
        else $error("timer 8 clock not ground");
    a_cmp_select: assert property (@(posedge ref_clk) disable iff (reset)
        clkEn && tmrSel_ff[14:8] == 7'h01 |=> timer9ExternalClock == $past(cmpSync_ff))
        else $error("timer 9 clock not comparator");
    a_reserved_code: assert property (@(posedge ref_clk) disable iff (reset)
        clkEn && tmrSel_ff[6:0] == 7'h5a |=> !timer8ExternalClock)
        else $error("reserved code drove timer 8");
    a_pin66_route: assert property (@(posedge ref_clk) disable iff (reset)
        clkEn |=> remapPin66 == $past(peripheralFunctionOut[outSel1_ff[5:0]]))
        else $error("pin 66 routing wrong");
    a_pin67_route: assert property (@(posedge ref_clk) disable iff (reset)
        clkEn |=> remapPin67 == $past(peripheralFunctionOut[outSel1_ff[13:8]]))
        else $error("pin 67 routing wrong");
    a_pin68_route: assert property (@(posedge ref_clk) disable iff (reset)
        clkEn |=> remapPin68 == $past(peripheralFunctionOut[outSel2_ff[5:0]]))
        else $error("pin 68 routing wrong");
    a_pin69_route: assert property (@(posedge ref_clk) disable iff (reset)
        clkEn |=> remapPin69 == $past(peripheralFunctionOut[outSel2_ff[13:8]]))
        else $error("pin 69 routing wrong");

    ////////////////////////////////////////////////////////////////////////////////
    // bus-side checks, then clock-enable and timer-source checks
    // write address phase, then its data phase
    sequence s_wr_tmr_sel;
        clkEn && addrPhase && hwrite && haddr[RPS_ADDR_W-1:0] == RPS_ADDR_TMR_SEL ##1 clkEn;
    endsequence
    sequence s_wr_out_sel1;
        clkEn && addrPhase && hwrite && haddr[RPS_ADDR_W-1:0] == RPS_ADDR_OUT_SEL1 ##1 clkEn;
    endsequence
    sequence s_wr_out_sel2;
        clkEn && addrPhase && hwrite && haddr[RPS_ADDR_W-1:0] == RPS_ADDR_OUT_SEL2 ##1 clkEn;
    endsequence
    // read address phase with no write landing alongside
    sequence s_rd_tmr_sel;
        clkEn && addrPhase && !hwrite && !wrPend_ff && haddr[RPS_ADDR_W-1:0] == RPS_ADDR_TMR_SEL;
    endsequence
    sequence s_rd_out_sel1;
        clkEn && addrPhase && !hwrite && !wrPend_ff && haddr[RPS_ADDR_W-1:0] == RPS_ADDR_OUT_SEL1;
    endsequence
    sequence s_rd_out_sel2;
        clkEn && addrPhase && !hwrite && !wrPend_ff && haddr[RPS_ADDR_W-1:0] == RPS_ADDR_OUT_SEL2;
    endsequence

    a_wr_tmr_sel: assert property (@(posedge ref_clk) disable iff (reset)
        s_wr_tmr_sel |=> tmrSel_ff == ($past(hwdata[15:0]) & RPS_TMR_MASK))
        else $error("input select write lost");
    a_wr_out_sel1: assert property (@(posedge ref_clk) disable iff (reset)
        s_wr_out_sel1 |=> outSel1_ff == ($past(hwdata[15:0]) & RPS_OUT_MASK))
        else $error("output select 1 write lost");
    a_wr_out_sel2: assert property (@(posedge ref_clk) disable iff (reset)
        s_wr_out_sel2 |=> outSel2_ff == ($past(hwdata[15:0]) & RPS_OUT_MASK))
        else $error("output select 2 write lost");

    a_rd_tmr_sel: assert property (@(posedge ref_clk) disable iff (reset)
        s_rd_tmr_sel |=> hrdata == {16'h0000, $past(tmrSel_ff)})
        else $error("input select read wrong");
    a_rd_out_sel1: assert property (@(posedge ref_clk) disable iff (reset)
        s_rd_out_sel1 |=> hrdata == {16'h0000, $past(outSel1_ff)})
        else $error("output select 1 read wrong");
    a_rd_out_sel2: assert property (@(posedge ref_clk) disable iff (reset)
        s_rd_out_sel2 |=> hrdata == {16'h0000, $past(outSel2_ff)})
        else $error("output select 2 read wrong");

    a_rd_unmapped: assert property (@(posedge ref_clk) disable iff (reset)
        clkEn && addrPhase && !hwrite && haddr[RPS_ADDR_W-1:0] != RPS_ADDR_TMR_SEL &&
        haddr[RPS_ADDR_W-1:0] != RPS_ADDR_OUT_SEL1 && haddr[RPS_ADDR_W-1:0] != RPS_ADDR_OUT_SEL2
        |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_rd_upper_zero: assert property (@(posedge ref_clk) disable iff (reset)
        hrdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_tmr_sel_unimpl: assert property (@(posedge ref_clk) disable iff (reset)
        (tmrSel_ff & ~RPS_TMR_MASK) == 16'h0000)
        else $error("unimplemented input-select bits set");
    a_freeze_hold: assert property (@(posedge ref_clk) disable iff (reset)
        !clkEn |=> $stable(tmrSel_ff) && $stable(outSel1_ff) && $stable(outSel2_ff) &&
        $stable(outPins_ff) && $stable(rdData_ff))
        else $error("state moved with clock enable low");

    a_pin_select: assert property (@(posedge ref_clk) disable iff (reset)
        clkEn && tmrSel_ff[6:0] == 7'h7f |=> timer8ExternalClock == $past(pinSync_ff[127]))
        else $error("timer 8 clock not from pin");
    a_t9_reserved: assert property (@(posedge ref_clk) disable iff (reset)
        clkEn && tmrSel_ff[14:8] == 7'h67 |=> !timer9ExternalClock)
        else $error("reserved code drove timer 9");
    a_t9_gnd: assert property (@(posedge ref_clk) disable iff (reset)
        clkEn && tmrSel_ff[14:8] == 7'h00 |=> !timer9ExternalClock)
        else $error("timer 9 clock not ground");
endmodule : remappable_pin_select
`default_nettype wire

// ---- rps_far_side.sv ----
`timescale 1ns/10ps
`default_nettype none
module rps_far_side
    import rps_pkg::*;
(
    input  wire logic                  flip,
    output logic      [RPS_NUM_IN-1:0] pinLevel,
    output logic                       cmpLevel,
    output logic      [RPS_NUM_FN-1:0] fnLevel
);
    // odd-numbered pins and functions sit high, flip inverts every source
    assign pinLevel = {(RPS_NUM_IN/2){2'b10}} ^ {RPS_NUM_IN{flip}};
    assign cmpLevel = ~flip;
    assign fnLevel  = {(RPS_NUM_FN/2){2'b10}} ^ {RPS_NUM_FN{flip}};
endmodule : rps_far_side
`default_nettype wire

// ---- remappable_pin_select_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module remappable_pin_select_tb
    import rps_pkg::*;
;
    logic                  ref_clk;
    logic                  reset;
    logic                  clkEn;
    logic                  hsel;
    logic [31:0]           haddr;
    logic [1:0]            htrans;
    logic                  hwrite;
    logic [31:0]           hwdata;
    logic [31:0]           hrdata;
    logic                  hreadyout;
    logic                  flip;
    logic [RPS_NUM_IN-1:0] pinLevel;
    logic                  cmpLevel;
    logic [RPS_NUM_FN-1:0] fnLevel;
    logic                  t8Clk;
    logic                  t9Clk;
    logic [3:0]            pins;
    int                    failures;
    int                    n_tests;
    logic [7:0]            addrs [4] = '{RPS_ADDR_TMR_SEL, RPS_ADDR_OUT_SEL1, RPS_ADDR_OUT_SEL2, 8'h0c};
    logic [31:0]           masks [4] = '{32'h7f7f, 32'h3f3f, 32'h3f3f, 32'h0};
    logic [6:0]            inCodes [9] = '{7'h00, 7'h01, 7'h2b, 7'h59, 7'h5a, 7'h60, 7'h67, 7'h7e, 7'h7f};

    remappable_pin_select dut_u (.ref_clk(ref_clk), .reset(reset), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .remappablePinIn(pinLevel), .comparator1Output(cmpLevel),
        .peripheralFunctionOut(fnLevel), .timer8ExternalClock(t8Clk), .timer9ExternalClock(t9Clk),
        .remapPin66(pins[0]), .remapPin67(pins[1]), .remapPin68(pins[2]), .remapPin69(pins[3]));
    rps_far_side far_u (.flip(flip), .pinLevel(pinLevel), .cmpLevel(cmpLevel), .fnLevel(fnLevel));

    always #20 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= RPS_HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    function automatic logic exp_in(input logic [6:0] c, input logic f);
        if (c == RPS_CODE_GND || c == 7'h5a || c == 7'h67) return 1'b0;
        if (c == RPS_CODE_COMPARATOR1_OUTPUT) return ~f;
        return c[0] ^ f;
    endfunction : exp_in

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] q;
        logic        e;
        ref_clk = 1'b0;
        reset = 1'b1;
        clkEn = 1'b1;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = '0;
        flip = 1'b0;
        failures = 0;
        n_tests = 0;
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            bus(addrs[i], 1'b0, 32'h0, q);
            check("reset value", q, 32'h0);
        end
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            bus(addrs[i], 1'b1, 32'hffff_ffff, q);
            bus(addrs[i], 1'b0, 32'h0, q);
            check("register readback", q, masks[i]);
        end
        $display("test readback done");
        for (int i = 0; i < 9; i++) begin
            bus(RPS_ADDR_TMR_SEL, 1'b1, {17'h0, inCodes[i], 1'b0, inCodes[i]}, q);
            for (int f = 0; f < 2; f++) begin
                flip <= f[0];
                repeat (6) @(posedge ref_clk);
                e = exp_in(inCodes[i], f[0]);
                check("timer clocks", {30'h0, t9Clk, t8Clk}, {30'h0, e, e});
            end
        end
        $display("test input routing done");
        bus(RPS_ADDR_OUT_SEL1, 1'b1, 32'h3f00, q);
        bus(RPS_ADDR_OUT_SEL2, 1'b1, 32'h152a, q);
        for (int f = 0; f < 2; f++) begin
            flip <= f[0];
            repeat (4) @(posedge ref_clk);
            check("pins 69 to 66", {28'h0, pins}, {28'h0, ~f[0], f[0], ~f[0], f[0]});
        end
        $display("test output routing done");
        clkEn <= 1'b0;
        flip <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check("frozen pins", {28'h0, pins}, 32'h5);
        check("frozen timer clocks", {30'h0, t9Clk, t8Clk}, 32'h0);
        clkEn <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check("thawed pins", {28'h0, pins}, 32'ha);
        check("thawed timer clocks", {30'h0, t9Clk, t8Clk}, 32'h3);
        $display("test clock enable done");
        reset <= 1'b1;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            bus(addrs[i], 1'b0, 32'h0, q);
            check("value after second reset", q, 32'h0);
        end
        check("pins after second reset", {26'h0, t9Clk, t8Clk, pins}, 32'h0);
        $display("test second reset done");
        close_out();
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        close_out();
    end
endmodule : remappable_pin_select_tb
`default_nettype wire
